// ---- design/dlprc_core.sv ----
`timescale 1ns/10ps
`include "dlprc_defines.svh"
// Function
// (R01) Write-update-all stores code, loads every channel
// (R02) Unchanged holding channels keep output untouched
// (R03) Write-update-selected loads only addressed channels
// (R04) Multibyte flag, address, MSB-first code fields
// (R05) Host uses transfer-all to load without writing; no transfer-all opcode is decoded here
// (R06) Power setting applied to masked channels only
// (R07) Power codes: normal, 1k, 100k, high-Z
// (R08) All channels down means standby
// (R09) Output registers kept through standby
// (R10) Commands still run while powered down
// (R11) Reference off in standby unless always-on
// (R12) Zero-scale clear keeps configuration
// (R13) Default restore resets everything incl config
// (R14) Address 1XX all, else one channel
// (R15) Transparent latch drives holding value out
// (R16) Always-on bit defaults zero, keeps reference
// (R17) Opcode B21..B19, B23 zero, after three bytes
// (R18) Reset: codes zero, normal power, no standby
module dlprc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output dlprc_pkg::dlprc_chan_type [3:0] chan_out,
  output logic standby,
  output logic ref_enable
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  dlprc_pkg::dlprc_frame_type frame;
  dlprc_pkg::dlprc_power_type power [4];
  logic [7:0] cmd_byte;
  logic [7:0] high_byte;
  logic [3:0][11:0] hold;
  logic [3:0][11:0] outreg;
  logic [3:0] dirty;
  logic [6:0] cfg;
  logic wr_acc;
  logic byte_wr;
  logic exec;
  logic [23:0] word;
  logic [2:0] op;
  logic [11:0] code;
  logic [3:0] sel_m;
  logic wr_code;
  logic [3:0] wmask;
  logic [3:0] next_dirty;
  logic [3:0] xfer;
  logic soft_any;
  logic soft_def;
  logic all_down;
  logic [31:0] rd_data;
  logic rd_ok;

  // Channel select from the three address bits
  function automatic logic [3:0] chan_sel(input logic [2:0] a);
    if (a[2]) begin
      chan_sel = 4'hF; // R14
    end else begin
      chan_sel = 4'h1 << a[1:0]; // R14
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  // Completed APB write and the command byte port
  assign wr_acc = psel & penable & pready & pwrite;
  assign byte_wr = wr_acc && (paddr == `DLPRC_OFF_CMD);
  // Word as it stands when its last byte lands
  assign word = {cmd_byte, high_byte, pwdata[7:0]};
  // Run only on a frame's low byte (the third, or the last of a repeated pair) with the reserved bit clear
  assign exec = byte_wr && (frame == dlprc_pkg::FR_LOW)
    && !word[`DLPRC_RSV_BIT]; // R17
  assign op = word[`DLPRC_OP_HI:`DLPRC_OP_LO]; // R17
  assign code = word[`DLPRC_CODE_HI:`DLPRC_CODE_LO]; // R04
  assign sel_m = chan_sel(word[`DLPRC_ALL_BIT:`DLPRC_ADDR_LO]); // R04
  assign soft_any = exec && (op == dlprc_pkg::OP_SOFT);
  assign soft_def = soft_any && word[`DLPRC_CLR_BIT];

  // Dirty tracking and which outputs a load really touches
  always_comb begin
    wr_code = exec && ((op == dlprc_pkg::OP_WR_ALL)
      || (op == dlprc_pkg::OP_WR_SEL));
    wmask = wr_code ? sel_m : 4'h0;
    next_dirty = dirty | wmask;
    if (!wr_code) begin
      xfer = 4'h0;
    end else if (op == dlprc_pkg::OP_WR_ALL) begin
      xfer = next_dirty; // R01 R02
    end else begin
      xfer = next_dirty & sel_m; // R03 R02
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte framing

  // Collect command, high and low bytes; multibyte repeats data pairs for write commands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame <= dlprc_pkg::FR_CMD;
      cmd_byte <= 8'h00;
      high_byte <= 8'h00;
    end else if (wr_acc && (paddr == `DLPRC_OFF_CTRL)
        && pwdata[`DLPRC_CTRL_END_BIT]) begin
      frame <= dlprc_pkg::FR_CMD; // Frame ended by software
    end else if (byte_wr) begin // R10
      case (frame)
        dlprc_pkg::FR_CMD: begin
          cmd_byte <= pwdata[7:0];
          frame <= dlprc_pkg::FR_HIGH;
        end
        dlprc_pkg::FR_HIGH: begin
          high_byte <= pwdata[7:0];
          frame <= dlprc_pkg::FR_LOW;
        end
        dlprc_pkg::FR_LOW: begin
          if (word[`DLPRC_MB_BIT] && wr_code) begin
            frame <= dlprc_pkg::FR_HIGH; // R04
          end else begin
            frame <= dlprc_pkg::FR_CMD;
          end
        end
        default: begin
          frame <= dlprc_pkg::FR_CMD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Holding and output registers

  // Store codes, load outputs, clear on soft commands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= {4{`DLPRC_CODE_RST}}; // R18
      outreg <= {4{`DLPRC_CODE_RST}}; // R18
      dirty <= 4'h0;
    end else if (soft_any) begin
      hold <= {4{`DLPRC_CODE_RST}}; // R12 R13
      outreg <= {4{`DLPRC_CODE_RST}}; // R12 R13
      dirty <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wmask[i]) begin
          hold[i] <= code;
        end
        if (xfer[i]) begin
          outreg[i] <= wmask[i] ? code : hold[i]; // R01 R03
        end
      end
      dirty <= next_dirty & ~xfer; // R02
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power settings

  // Masked channels take the new setting, others hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        power[i] <= dlprc_pkg::PWR_NORMAL; // R18
      end
    end else if (soft_def) begin
      for (int i = 0; i < 4; i++) begin
        power[i] <= dlprc_pkg::PWR_NORMAL; // R13
      end
    end else if (exec && (op == dlprc_pkg::OP_POWER)) begin
      for (int i = 0; i < 4; i++) begin
        if (word[`DLPRC_MASK_LO + i]) begin
          power[i] <= dlprc_pkg::dlprc_power_type'(
            word[`DLPRC_PWR_HI:`DLPRC_PWR_LO]); // R06 R07
        end
      end
    end
  end

  // Every channel in a power-down setting
  always_comb begin
    all_down = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (power[i] == dlprc_pkg::PWR_NORMAL) begin
        all_down = 1'b0; // R08
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration

  // Latch modes, always-on and reference select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= `DLPRC_CFG_RST; // R16
    end else if (soft_def) begin
      cfg <= `DLPRC_CFG_RST; // R13
    end else if (wr_acc && (paddr == `DLPRC_OFF_CFG)) begin
      cfg <= pwdata[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog-side outputs

  // Standby, reference enable and channel levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby <= 1'b0; // R18
      ref_enable <= 1'b0;
      chan_out <= '0;
    end else begin
      standby <= all_down; // R08
      ref_enable <= (cfg[`DLPRC_CFG_REF_HI:`DLPRC_CFG_REF_LO] != 2'h0)
        && (!all_down || cfg[`DLPRC_CFG_AON_BIT]); // R11 R16
      for (int i = 0; i < 4; i++) begin
        chan_out[i].power <= power[i];
        chan_out[i].level <= cfg[`DLPRC_CFG_LATCH_LO + i]
          ? hold[i] : outreg[i]; // R15 R09
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave

  // Read mux and address check
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (paddr == `DLPRC_OFF_CMD) begin
      rd_data = {22'h000000, frame, cmd_byte};
    end else if (paddr == `DLPRC_OFF_CTRL) begin
      rd_data = 32'h0000_0000;
    end else if (paddr == `DLPRC_OFF_CFG) begin
      rd_data = {25'h0000000, cfg};
    end else if (paddr == `DLPRC_OFF_STAT) begin
      rd_data = {22'h000000, power[3], power[2], power[1], power[0],
        ref_enable, standby};
    end else if ((paddr[11:4] == `DLPRC_PAGE_HOLD)
        && (paddr[1:0] == 2'h0)) begin
      rd_data = {20'h00000, hold[paddr[3:2]]};
    end else if ((paddr[11:4] == `DLPRC_PAGE_OUT)
        && (paddr[1:0] == 2'h0)) begin
      rd_data = {20'h00000, outreg[paddr[3:2]]};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // One access cycle, answer prepared in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable & ~pready;
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= ~rd_ok;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  exec_frame_a: assert property (exec // R17
      |-> frame == dlprc_pkg::FR_LOW && byte_wr)
    else $error("command ran before its third byte");

  load_all_a: assert property (exec && op == dlprc_pkg::OP_WR_ALL // R01
      |=> dirty == 4'h0)
    else $error("load-all left a channel pending");

  quiet_ch_a: assert property (exec && op == dlprc_pkg::OP_WR_ALL // R02
      && !dirty[0] && !sel_m[0] |=> $stable(outreg[0]))
    else $error("unchanged channel output rewritten");

  load_sel_a: assert property (exec && op == dlprc_pkg::OP_WR_SEL // R03
      && sel_m[1] |=> outreg[1] == $past(code))
    else $error("selected channel not loaded");

  power_set_a: assert property (exec && op == dlprc_pkg::OP_POWER // R06
      && word[0] |=> power[0] == $past(word[5:4]))
    else $error("power setting not applied");

  power_keep_a: assert property (exec && op == dlprc_pkg::OP_POWER // R06
      && !word[2] |=> $stable(power[2]))
    else $error("unselected channel power changed");

  standby_a: assert property (all_down // R08
      |=> standby ##1 (standby || !$past(all_down)))
    else $error("standby does not follow power state");

  standby_off_a: assert property (!all_down |=> !standby) // R08
    else $error("standby kept with a channel running");

  // Reference enable is computed from last cycle's settings
  ref_off_a: assert property (standby && !$past(cfg[4]) // R11
      |-> !ref_enable)
    else $error("reference on during standby");

  aon_keep_a: assert property (cfg[4] && cfg[6:5] != 2'h0 // R16
      |=> ref_enable)
    else $error("always-on reference dropped");

  retain_a: assert property (standby && !soft_any && !wr_code // R09
      |=> $stable(outreg))
    else $error("output register lost in standby");

  latch_pass_a: assert property (cfg[0] // R15
      |=> chan_out[0].level == $past(hold[0]))
    else $error("transparent latch not passing code");

  clear_a: assert property (soft_any && !word[0] // R12
      |=> hold == '0 && outreg == '0 && $stable(cfg))
    else $error("clear did not zero codes");

  default_a: assert property (soft_def // R13
      |=> cfg == 7'h00 && power[3] == dlprc_pkg::PWR_NORMAL)
    else $error("default restore incomplete");

  cv_load_all: cover property (exec && op == dlprc_pkg::OP_WR_ALL);
  cv_multibyte: cover property (exec && word[22] ##[1:20] exec);
  cv_standby: cover property ($rose(standby));
  cv_restore: cover property (soft_def);
  cv_transparent: cover property (cfg[0] && exec);

endmodule

// ---- design/dlprc_defines.svh ----
`ifndef DLPRC_DEFINES_SVH
`define DLPRC_DEFINES_SVH

// APB byte offsets
`define DLPRC_OFF_CMD 12'h000
`define DLPRC_OFF_CTRL 12'h004
`define DLPRC_OFF_CFG 12'h008
`define DLPRC_OFF_STAT 12'h00C
`define DLPRC_PAGE_HOLD 8'h01
`define DLPRC_PAGE_OUT 8'h02

// Command word fields, bit 23 is the command byte MSB
`define DLPRC_RSV_BIT 23
`define DLPRC_MB_BIT 22
`define DLPRC_OP_HI 21
`define DLPRC_OP_LO 19
`define DLPRC_ALL_BIT 18
`define DLPRC_ADDR_HI 17
`define DLPRC_ADDR_LO 16
`define DLPRC_CODE_HI 15
`define DLPRC_CODE_LO 4
`define DLPRC_PWR_HI 5
`define DLPRC_PWR_LO 4
`define DLPRC_MASK_HI 3
`define DLPRC_MASK_LO 0
`define DLPRC_CLR_BIT 0

// Config register fields
`define DLPRC_CFG_LATCH_HI 3
`define DLPRC_CFG_LATCH_LO 0
`define DLPRC_CFG_AON_BIT 4
`define DLPRC_CFG_REF_HI 6
`define DLPRC_CFG_REF_LO 5
`define DLPRC_CTRL_END_BIT 0

// Reset values
`define DLPRC_CFG_RST 7'h00
`define DLPRC_CODE_RST 12'h000

`endif

// ---- design/dlprc_pkg.sv ----
package dlprc_pkg;

  // Frame byte position, Gray along cmd -> high -> low
  typedef enum logic [1:0] {
    FR_CMD = 2'h0,
    FR_HIGH = 2'h1,
    FR_LOW = 2'h3
  } dlprc_frame_type;

  // Opcodes handled by this block
  typedef enum logic [2:0] {
    OP_WR_ALL = 3'h2,
    OP_WR_SEL = 3'h3,
    OP_POWER = 3'h4,
    OP_SOFT = 3'h5
  } dlprc_op_type;

  // Per-channel power setting
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'h0,
    PWR_1K = 2'h1,
    PWR_100K = 2'h2,
    PWR_HIZ = 2'h3
  } dlprc_power_type;

  // What one channel presents to the analog side
  typedef struct packed {
    dlprc_power_type power;
    logic [11:0] level;
  } dlprc_chan_type;

endpackage

// ---- sim/dlprc_host.sv ----
`timescale 1ns/10ps
`include "dlprc_defines.svh"
// Host side: APB master feeding command bytes
module dlprc_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  ////////////////////////////////////////
  // One transfer, held until pready
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;  // No stale value when idle
    pwdata <= ~d;
  endtask
  // Frame: command, high, low byte; B23 as given, set by one caller to test refusal
  task automatic send(input logic [23:0] w);
    logic [31:0] q;
    logic e;
    xfer(1'b1, `DLPRC_OFF_CMD, {24'h0, w[23:16]}, q, e);
    pair(w[15:0]);
  endtask
  // Data pair; loads without writing would use transfer-all
  task automatic pair(input logic [15:0] v);
    logic [31:0] q;
    logic e;
    xfer(1'b1, `DLPRC_OFF_CMD, {24'h0, v[15:8]}, q, e);
    xfer(1'b1, `DLPRC_OFF_CMD, {24'h0, v[7:0]}, q, e);
  endtask
endmodule

// ---- sim/test_dac_load_power_reset_commands.sv ----
`timescale 1ns/10ps
`include "dlprc_defines.svh"
module test_dac_load_power_reset_commands;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, standby, ref_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  dlprc_pkg::dlprc_chan_type [3:0] chan_out;
  int err_total;
  int check_count;
  int cycles;
  dlprc_host host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  dlprc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_out(chan_out), .standby(standby), .ref_enable(ref_enable));
  ////////////////////////////////////////
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  // Helpers
  task automatic chk(input string n, input logic [31:0] x,
      input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask
  task automatic rdc(input string n, input logic [11:0] a,
      input logic [31:0] x);
    host.xfer(1'b0, a, 32'h0, q, e);
    chk(n, x, q);
  endtask
  task automatic lvl(input int i, input logic [11:0] x);
    chk("level", {20'h0, x}, {20'h0, chan_out[i].level});
  endtask
  function automatic logic [7:0] cb(int m, logic [2:0] op, logic [2:0] a);
    return {1'b0, m[0], op, a};
  endfunction
  task automatic settle();
    repeat (2) @(negedge pclk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    @(negedge pclk);
    for (int i = 0; i < 4; i++) lvl(i, 12'h000);
    rdc("stat", `DLPRC_OFF_STAT, 32'h0);
    rdc("cfg", `DLPRC_OFF_CFG, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_update();
    host.send({cb(0, dlprc_pkg::OP_WR_ALL, 3'h0), 12'hABC, 4'h0});
    settle();
    lvl(0, 12'hABC);
    rdc("hold0", 12'h010, 32'hABC);
    host.send({cb(0, dlprc_pkg::OP_WR_ALL, 3'h1), 12'h123, 4'hF});
    settle();
    lvl(1, 12'h123);
    lvl(0, 12'hABC);
    host.send({cb(0, dlprc_pkg::OP_WR_SEL, 3'h4), 12'h5A5, 4'h0});
    settle();
    for (int i = 0; i < 4; i++) lvl(i, 12'h5A5);
    host.send({cb(0, dlprc_pkg::OP_WR_SEL, 3'h3), 12'hFFF, 4'h0});
    settle();
    lvl(3, 12'hFFF);
    lvl(2, 12'h5A5);
    host.send({cb(1, dlprc_pkg::OP_WR_SEL, 3'h2), 12'h111, 4'h0});
    host.pair({12'h222, 4'h0});
    settle();
    lvl(2, 12'h222);
    rdc("frame", `DLPRC_OFF_CMD, {22'h0, 2'h1, 8'h5A});
    host.xfer(1'b1, `DLPRC_OFF_CTRL, 32'h1, q, e);
    rdc("frame", `DLPRC_OFF_CMD, 32'h5A);
    $display("update test done");
  endtask
  task automatic t_power();
    host.xfer(1'b1, `DLPRC_OFF_CFG, 32'h20, q, e);
    for (int p = 0; p < 4; p++) begin
      host.send({cb(0, dlprc_pkg::OP_POWER, 3'h0), 10'h0, 2'(p), 4'h1});
      settle();
      chk("power", p, {30'h0, chan_out[0].power});
      chk("power", 32'h0, {30'h0, chan_out[1].power});
    end
    host.send({cb(0, dlprc_pkg::OP_POWER, 3'h0), 16'h002F});
    settle();
    chk("standby", 32'h1, {31'h0, standby});
    chk("ref", 32'h0, {31'h0, ref_enable});
    host.send({cb(0, dlprc_pkg::OP_WR_SEL, 3'h0), 12'h777, 4'h0});
    settle();
    rdc("out0", 12'h020, 32'h777);
    rdc("out1", 12'h024, 32'h5A5);
    host.xfer(1'b1, `DLPRC_OFF_CFG, 32'h3F, q, e);
    settle();
    chk("ref", 32'h1, {31'h0, ref_enable});
    lvl(0, 12'h777);
    host.send({cb(0, dlprc_pkg::OP_POWER, 3'h0), 16'h0002});
    settle();
    chk("standby", 32'h0, {31'h0, standby});
    $display("power test done");
  endtask
  task automatic t_soft();
    host.send({cb(0, dlprc_pkg::OP_SOFT, 3'h0), 16'h0000});
    settle();
    rdc("out0", 12'h020, 32'h0);
    rdc("hold3", 12'h01C, 32'h0);
    rdc("cfg", `DLPRC_OFF_CFG, 32'h3F);
    host.send({cb(0, dlprc_pkg::OP_SOFT, 3'h0), 16'h0001});
    settle();
    rdc("cfg", `DLPRC_OFF_CFG, 32'h0);
    rdc("stat", `DLPRC_OFF_STAT, 32'h0);
    host.send({8'h90, 12'h999, 4'h0});
    settle();
    lvl(0, 12'h000);
    host.xfer(1'b0, 12'h0FC, 32'h0, q, e);
    chk("slverr", 32'h1, {31'h0, e});
    $display("soft and refusal test done");
  endtask
  // Main sequence
  initial begin
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_update();
    t_power();
    t_soft();
    wrap_up();
  end
endmodule
